// file: verilog/bhrp_pkg.sv
// Purpose: shared constants for the byte host register port
// Assumes: one clock at 200 MHz, synchronous host pins
// Notes: widths, timing, reset values and the cycle type; no register map lives here
package bhrp_pkg;
  localparam int ADDR_W = 9;              // host address width
  localparam int DATA_W = 8;              // host data width
  localparam int IRQ_W = 8;               // internal event sources
  localparam logic [7:0] DATA_RST = 8'h00; // bus output value at reset
  localparam int CLK_PERIOD_PS = 5000;    // clock period in ps
  localparam int RST_FILT_NS = 10;        // least width of a master reset pulse
  localparam int RST_FILT_CYC = (RST_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    BHRP_IDLE,
    BHRP_READ,
    BHRP_WRITE
  } bhrp_cycle_type;
endpackage

// file: verilog/bhrp_irq_merge.sv
// Purpose: merge internal interrupt conditions into one pending level
// Assumes: conditions are levels held by their owners until cleared
// Notes: open-drain style output, enable low while driving low
`timescale 1ns/1ps
module bhrp_irq_merge
  import bhrp_pkg::*;
#(
  parameter int N = IRQ_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic rst_low,
  // event conditions
  input wire logic [N-1:0] cond,
  // open-drain pin
  output logic irq_o,
  output logic irq_oe_low
);
  logic pend_q; // registered pending flag
  logic pend_d;

  initial begin
    if (N < 1) $error("bhrp_irq_merge needs at least one source");
  end

  // any pending condition pulls the line
  always_comb begin
    pend_d = |cond;
  end

  // async master reset clears pending at once
  always_ff @(posedge clk or negedge rst_low) begin
    if (!rst_low) begin
      pend_q <= 1'b0;
    end else if (srst) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign irq_o = 1'b0;        // only ever drives low
  assign irq_oe_low = ~pend_q; // low enables the driver
endmodule

// file: verilog/bhrp_port.sv
// Purpose: byte-wide host port decoding strobes onto internal registers
// Assumes: host pins synchronous to clk; registers answer in the same cycle
// Notes: write wins over read; data bus driven only during selected reads
`timescale 1ns/1ps
// Overview of operation
// - all nine address bits decoded
// - eight bit data bus, bit 7 msb
// - write strobe with select writes register
// - read strobe with select, no write, reads
// - both strobes low means write only
// - no access without chip select
// - interrupt pin low while event pending
// - master reset acts asynchronously
// - port serves configuration and packet data
module bhrp_port
  import bhrp_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W,
  parameter int NIRQ = IRQ_W
) (
  // clock and resets
  input wire logic clk,
  input wire logic srst,
  input wire logic master_reset_low,
  // host pins
  input wire logic [AW-1:0] host_register_address,
  input wire logic [DW-1:0] host_register_databus_i,
  output logic [DW-1:0] host_register_databus_o,
  output logic host_register_databus_oe_low,
  input wire logic host_write_strobe_low,
  input wire logic host_read_strobe_low,
  input wire logic host_select_low,
  output logic host_irq_low_o,
  output logic host_irq_low_oe_low,
  // internal register and fifo side
  output logic reg_wr_q,
  output logic reg_rd_q,
  output logic [AW-1:0] reg_addr_q,
  output logic [DW-1:0] reg_wdata_q,
  input wire logic [DW-1:0] reg_rdata,
  input wire logic [NIRQ-1:0] irq_cond
);
  bhrp_cycle_type cyc_d; // decoded cycle this clock
  bhrp_cycle_type cyc_q; // previous cycle, for edge detection
  // next and registered pin side values
  logic [DW-1:0] dout_d;
  logic [DW-1:0] dout_q;
  logic oe_low_d;
  logic oe_low_q;
  // next values of the internal register side
  logic wr_d;
  logic rd_d;
  logic [AW-1:0] addr_d;
  logic [DW-1:0] wdata_d;
  logic irq_drv;

  // refuse shapes the logic cannot serve
  // the address decode and byte lanes are fixed, so other widths are refused
  initial begin
    if (AW != 9) $error("address must be nine bits");
    if (DW != 8) $error("data must be eight bits");
  end

  // decode strobes; write dominates read
  // select gates everything, so stray strobes with select high do nothing
  // both strobes low is the combined r/w host case and must write
  always_comb begin
    cyc_d = BHRP_IDLE;
    if (!host_select_low) begin
      if (!host_write_strobe_low) begin
        cyc_d = BHRP_WRITE;
      end else if (!host_read_strobe_low) begin
        cyc_d = BHRP_READ;
      end
    end
  end

  // one pulse per host access; full nine bit address passed on
  // pulses fire on the first edge of an access only: a host holding its
  // strobe for many cycles must not pop the fifo twice, hence cyc_q
  // read data is still refreshed every cycle while the read is held
  always_comb begin
    wr_d = 1'b0;
    rd_d = 1'b0;
    addr_d = reg_addr_q;
    wdata_d = reg_wdata_q;
    dout_d = dout_q;
    oe_low_d = 1'b1;
    case (cyc_d)
      BHRP_WRITE: begin
        // pulse on entry only, address and data recaptured every cycle; a long strobe writes once; fifo pops stay single
        wr_d = (cyc_q != BHRP_WRITE);
        addr_d = host_register_address;
        wdata_d = host_register_databus_i;
      end
      BHRP_READ: begin
        rd_d = (cyc_q != BHRP_READ);
        addr_d = host_register_address;
        dout_d = reg_rdata;
        oe_low_d = 1'b0;
      end
      BHRP_IDLE: begin
        oe_low_d = 1'b1;
      end
      default: begin
        oe_low_d = 1'b1;
      end
    endcase
  end

  // register everything; master reset clears without clock
  // both resets load the same constants; the async one also covers a stopped clock
  always_ff @(posedge clk or negedge master_reset_low) begin
    if (!master_reset_low) begin
      cyc_q <= BHRP_IDLE;
      dout_q <= DATA_RST;
      oe_low_q <= 1'b1;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_addr_q <= '0;
      reg_wdata_q <= DATA_RST;
    end else if (srst) begin
      cyc_q <= BHRP_IDLE;
      dout_q <= DATA_RST;
      oe_low_q <= 1'b1;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_addr_q <= '0;
      reg_wdata_q <= DATA_RST;
    end else begin
      cyc_q <= cyc_d;
      dout_q <= dout_d;
      oe_low_q <= oe_low_d;
      reg_wr_q <= wr_d;
      reg_rd_q <= rd_d;
      reg_addr_q <= addr_d;
      reg_wdata_q <= wdata_d;
    end
  end

  // pin side straight from flops, so no decode glitch reaches the bus
  assign host_register_databus_o = dout_q;
  assign host_register_databus_oe_low = oe_low_q;

  // interrupt merge, registered inside
  // the pin value is a constant low and only the enable toggles, which is
  // what an open-drain pad with an external pull-up expects
  bhrp_irq_merge #(.N(NIRQ)) u_irq (
    .clk(clk),
    .srst(srst),
    .rst_low(master_reset_low),
    .cond(irq_cond),
    .irq_o(irq_drv),
    .irq_oe_low(host_irq_low_oe_low)
  );
  assign host_irq_low_o = irq_drv;

  // checks
  // strobe decode, first-edge pulses, interrupt drive and reset clear
  a_write_pulse: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    (!host_select_low && !host_write_strobe_low && $past(host_select_low)) |=> reg_wr_q)
    else $error("write not taken");
  a_write_wins: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    (!host_select_low && !host_write_strobe_low) |=> (!reg_rd_q && host_register_databus_oe_low))
    else $error("read during write");
  a_no_select: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    host_select_low |=> (!reg_wr_q && !reg_rd_q && host_register_databus_oe_low))
    else $error("access without select");
  a_read_drive: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    (!host_select_low && host_write_strobe_low && !host_read_strobe_low) |=>
      (!host_register_databus_oe_low && host_register_databus_o == $past(reg_rdata)))
    else $error("read data missing");
  a_bus_release: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    !host_register_databus_oe_low |->
      (!$past(host_select_low) && $past(host_write_strobe_low) && !$past(host_read_strobe_low)))
    else $error("bus driven outside read");
  a_addr_full: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    (!host_select_low && (!host_write_strobe_low || !host_read_strobe_low)) |=>
      reg_addr_q == $past(host_register_address))
    else $error("address not captured");
  a_wdata_byte: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    reg_wr_q |-> reg_wdata_q == $past(host_register_databus_i))
    else $error("write data wrong");
  a_irq_level: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    (|irq_cond) [*2] |-> !host_irq_low_oe_low && !host_irq_low_o)
    else $error("interrupt not driven");
  a_single_wr: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    reg_wr_q |=> !reg_wr_q)
    else $error("write pulse too long");
  a_reset_idle: assert property (@(posedge clk)
    !master_reset_low |-> (host_register_databus_oe_low && !reg_wr_q && !reg_rd_q))
    else $error("reset did not clear");

  // entry pulses and turnaround
  a_read_pulse: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    (!host_select_low && host_write_strobe_low && !host_read_strobe_low && $past(host_select_low))
      |=> reg_rd_q)
    else $error("read not taken");
  a_turn_write: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    (!host_select_low && !host_write_strobe_low && !$past(host_select_low) &&
      $past(host_write_strobe_low) && !$past(host_read_strobe_low)) |=> reg_wr_q)
    else $error("write after read lost");
  a_single_rd: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    reg_rd_q |=> !reg_rd_q)
    else $error("read pulse too long");
  // address capture and hold
  a_wr_addr: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    reg_wr_q |-> reg_addr_q == $past(host_register_address))
    else $error("write address wrong");
  a_addr_hold: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    host_select_low |=> $stable(reg_addr_q))
    else $error("address moved without select");
  // interrupt release
  a_irq_release: assert property (@(posedge clk) disable iff (srst || !master_reset_low)
    (!(|irq_cond)) [*2] |-> host_irq_low_oe_low)
    else $error("interrupt held without cause");

  c_write: cover property (@(posedge clk) reg_wr_q);
  c_read: cover property (@(posedge clk) reg_rd_q);
  c_both_low: cover property (@(posedge clk)
    !host_select_low && !host_write_strobe_low && !host_read_strobe_low);
  c_irq: cover property (@(posedge clk) !host_irq_low_oe_low);
  // read straight into write, the combined r/w host pattern
  c_read_to_write: cover property (@(posedge clk)
    reg_rd_q ##1 (!host_select_low && !host_write_strobe_low));
endmodule

// file: test/bhrp_host_model.sv
// Purpose: host processor model for the byte host port
// Assumes: strobes change just after a rising edge
// Notes: a released bus shows the inverse of the last host byte
`timescale 1ns/1ps
module bhrp_host_model
  import bhrp_pkg::*;
(
  // clock
  input wire logic clk,
  // host pins
  output logic [ADDR_W-1:0] addr,
  output logic wr_low,
  output logic rd_low,
  output logic cs_low,
  // data bus
  input wire logic [DATA_W-1:0] dev_data,
  input wire logic dev_oe_low,
  output logic [DATA_W-1:0] bus
);
  logic [DATA_W-1:0] hdata; // host byte
  // host drives only while writing, so an undriven bus never looks valid
  assign bus = !wr_low ? hdata : (!dev_oe_low ? dev_data : ~hdata);
  // idle host at time zero
  initial begin
    addr = '0;
    hdata = '0;
    wr_low = 1'b1;
    rd_low = 1'b1;
    cs_low = 1'b1;
  end
  // present pin levels at the next edge
  task automatic drive(input logic cs, input logic wr, input logic rd,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    cs_low <= cs;
    wr_low <= wr;
    rd_low <= rd;
    addr <= a;
    hdata <= d;
  endtask
endmodule

// file: test/bhrp_port_tb_top.sv
// Purpose: self-checking bench for the byte host port
// Assumes: registered answers appear just after the sampling edge, one cycle after the host drives
// Notes: master reset drops just after an edge and must act before the next
`timescale 1ns/1ps
module bhrp_port_tb_top;
  import bhrp_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic mrst_low = 1'b1;
  logic [DATA_W-1:0] rdata = 8'h00;
  logic [IRQ_W-1:0] irq = 8'h00;
  logic [ADDR_W-1:0] addr, a_q;
  logic [DATA_W-1:0] bus, dout, wd_q;
  logic wr_low, rd_low, cs_low, oe_low, irq_o, irq_oe_low, wr_q, rd_q;
  int num_errors = 0;
  int n_checks = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  bhrp_host_model u_host(.clk(clk), .addr(addr), .wr_low(wr_low), .rd_low(rd_low),
    .cs_low(cs_low), .dev_data(dout), .dev_oe_low(oe_low), .bus(bus));
  bhrp_port u_dut(.clk(clk), .srst(srst), .master_reset_low(mrst_low),
    .host_register_address(addr), .host_register_databus_i(bus),
    .host_register_databus_o(dout), .host_register_databus_oe_low(oe_low),
    .host_write_strobe_low(wr_low), .host_read_strobe_low(rd_low),
    .host_select_low(cs_low), .host_irq_low_o(irq_o), .host_irq_low_oe_low(irq_oe_low),
    .reg_wr_q(wr_q), .reg_rd_q(rd_q), .reg_addr_q(a_q), .reg_wdata_q(wd_q),
    .reg_rdata(rdata), .irq_cond(irq));
  // compare and count
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait one edge, then let its updates land
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic t_write();
    u_host.drive(1'b0, 1'b0, 1'b1, 9'h1a5, 8'h5a);
    tick();
    check(wr_q, 9'h001);
    check(a_q, 9'h1a5);
    check(wd_q, 8'h5a);
    u_host.drive(1'b1, 1'b1, 1'b1, 9'h000, 8'h00);
    #1;
    check(wr_q, 9'h000);
    $display("write test done");
  endtask
  task automatic t_read();
    @(posedge clk);
    rdata <= 8'hc3;
    u_host.drive(1'b0, 1'b1, 1'b0, 9'h0ff, 8'h00);
    tick();
    check(rd_q, 9'h001);
    check(oe_low, 9'h000);
    check(bus, 8'hc3);
    u_host.drive(1'b1, 1'b1, 1'b1, 9'h000, 8'h00);
    tick();
    check(oe_low, 9'h001);
    $display("read test done");
  endtask
  task automatic t_both();
    u_host.drive(1'b0, 1'b0, 1'b0, 9'h003, 8'h81);
    tick();
    check({wr_q, rd_q, oe_low}, 3'b101);
    check(wd_q, 8'h81);
    u_host.drive(1'b1, 1'b1, 1'b1, 9'h000, 8'h00);
    u_host.drive(1'b1, 1'b0, 1'b0, 9'h004, 8'h11);
    tick();
    check({wr_q, rd_q, oe_low}, 3'b001);
    u_host.drive(1'b1, 1'b1, 1'b1, 9'h000, 8'h00);
    $display("strobe test done");
  endtask
  task automatic t_irq();
    @(posedge clk);
    irq <= 8'h80;
    rdata <= 8'h80; // cause byte as the interrupt register shows it
    tick();
    tick();
    check({irq_oe_low, irq_o}, 2'b00);
    u_host.drive(1'b0, 1'b1, 1'b0, 9'h1f0, 8'h00);
    tick();
    check(bus, 8'h80);
    u_host.drive(1'b1, 1'b1, 1'b1, 9'h000, 8'h00);
    irq <= 8'h00;
    tick();
    check(irq_oe_low, 9'h001);
    $display("interrupt test done");
  endtask
  task automatic t_mrst();
    u_host.drive(1'b0, 1'b1, 1'b0, 9'h010, 8'h00);
    tick();
    check(oe_low, 9'h000);
    @(posedge clk);
    mrst_low <= 1'b0; // must clear before the next edge
    #1;
    check({oe_low, rd_q}, 2'b10);
    check(a_q, 9'h000);
    u_host.drive(1'b1, 1'b1, 1'b1, 9'h000, 8'h00);
    mrst_low <= 1'b1;
    tick();
    tick();
    check({oe_low, rd_q, wr_q}, 3'b100);
    $display("master reset test done");
  endtask
  // closing report
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    tick();
    t_write();
    t_read();
    t_both();
    t_irq();
    t_mrst();
    print_verdict();
  end
  // watchdog, about twenty-eight times the expected run
  initial begin
    #5000;
    num_errors++;
    print_verdict();
  end
endmodule
